// file: verilog/dcsr_repeater.sv
/*
  Receive-and-repeat serial front end of a cascadable LED driver:
  captures 40-bit words on the upstream shift clock, repeats clock
  and data downstream in one of three timing modes, and applies the
  received words when the shift clock has been idle long enough.
  Assumes the differential receivers and drivers sit outside, and
  that the upstream shift clock stops between frames.
*/
`timescale 1ns/10ps
`default_nettype none
module dcsr_repeater #(
    parameter dcsr_pkg::dcsr_tab_t LAT_WAIT_CYC = dcsr_pkg::LAT_WAIT_CYC
) (
    // System clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Upstream link
    input wire logic shiftClockInPos,
    input wire logic serialDataInPos,
    // Downstream link
    output logic shiftClockOutPos,
    output logic shiftClockOutNeg,
    output logic serialDataOutPos,
    output logic serialDataOutNeg,
    // Active word and configuration
    output logic latchPulse,
    output logic [39:0] activeWord,
    output logic [1:0] modeSel,
    output logic [3:0] waitCode,
    // Register readback
    input wire logic [3:0] readAddr,
    output logic [35:0] readData
);

    // ****************************************
    // Link domain
    // ****************************************
    logic linkClr_reg;
    logic linkRst_n;
    logic [5:0] bitCnt_reg;
    logic [39:0] shift_reg;
    logic [39:0] hold_reg;
    logic lastBit_reg;
    logic wordTgl_reg;

    // Partial words are dropped by the latch, via a reset pulse
    assign linkRst_n = arst_n & ~linkClr_reg;

    always_ff @(posedge shiftClockInPos or negedge linkRst_n) begin
        if (!linkRst_n) begin
            shift_reg <= '0;
            bitCnt_reg <= '0;
        end else begin
            shift_reg <= {shift_reg[38:0], serialDataInPos};
            if (bitCnt_reg == dcsr_pkg::BIT_LAST) begin
                bitCnt_reg <= '0;
            end else begin
                bitCnt_reg <= bitCnt_reg + 6'h1;
            end
        end
    end

    // Toggle and holding word survive the frame clear
    always_ff @(posedge shiftClockInPos or negedge arst_n) begin
        if (!arst_n) begin
            hold_reg <= '0;
            wordTgl_reg <= 1'b0;
            lastBit_reg <= 1'b0;
        end else begin
            lastBit_reg <= serialDataInPos;
            if (bitCnt_reg == dcsr_pkg::BIT_LAST) begin
                hold_reg <= {shift_reg[38:0], serialDataInPos};
                wordTgl_reg <= ~wordTgl_reg;
            end
        end
    end

    // ****************************************
    // Crossing into the system clock
    // ****************************************
    logic sckSync;
    logic bitSync;
    logic tglSync;
    logic sckPrev_reg;
    logic tglPrev_reg;
    logic sckRise;
    logic sckFall;

    dcsr_sync2 #(.W(3)) u_sync (
        .clk(mclk),
        .rst_n(arst_n),
        .d({shiftClockInPos, lastBit_reg, wordTgl_reg}),
        .q({sckSync, bitSync, tglSync})
    );

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sckPrev_reg <= 1'b0;
            tglPrev_reg <= 1'b0;
        end else begin
            sckPrev_reg <= sckSync;
            tglPrev_reg <= tglSync;
        end
    end

    assign sckRise = sckSync & ~sckPrev_reg;
    assign sckFall = ~sckSync & sckPrev_reg;

    // ****************************************
    // Word capture and idle timer
    // ****************************************
    logic [39:0] pending_reg;
    logic pendValid_reg;
    logic [dcsr_pkg::TMR_W-1:0] idleCnt_reg;
    logic [dcsr_pkg::TMR_W-1:0] waitLim;
    logic armed_reg;
    logic latchTick;
    logic [1:0] dsiField_reg;
    logic [3:0] waitCode_reg;

    // Holding word is stable for 40 link periods after the toggle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pending_reg <= '0;
            pendValid_reg <= 1'b0;
        end else if (tglSync != tglPrev_reg) begin
            pending_reg <= hold_reg;
            pendValid_reg <= 1'b1;
        end else if (latchTick) begin
            pendValid_reg <= 1'b0;
        end
    end

    assign waitLim = dcsr_pkg::TMR_W'(LAT_WAIT_CYC[waitCode_reg] - 1);

    // Relies on the host keeping mid-frame gaps below the wait
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            idleCnt_reg <= '0;
            armed_reg <= 1'b0;
        end else if (sckRise) begin
            idleCnt_reg <= '0;
            armed_reg <= 1'b1;
        end else if (armed_reg) begin
            if (idleCnt_reg == waitLim) begin
                armed_reg <= 1'b0;
            end else begin
                idleCnt_reg <= idleCnt_reg + 1'b1;
            end
        end
    end

    assign latchTick = armed_reg & ~sckRise & (idleCnt_reg == waitLim);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            latchPulse <= 1'b0;
            linkClr_reg <= 1'b0;
        end else begin
            latchPulse <= latchTick;
            linkClr_reg <= latchTick;
        end
    end

    // ****************************************
    // Applying the word at the latch
    // ****************************************
    dcsr_mem_if memBus ();
    logic applyCfg;

    assign applyCfg = latchTick & pendValid_reg
        & (pending_reg[39:36] == dcsr_pkg::ADDR_CFG);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            activeWord <= '0;
        end else if (latchTick && pendValid_reg) begin
            activeWord <= pending_reg;
        end
    end

    // Nonvolatile storage is modelled as registers with defaults
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dsiField_reg <= dcsr_pkg::DSI_RESET;
            waitCode_reg <= dcsr_pkg::LAT_RESET;
        end else if (applyCfg) begin
            dsiField_reg <= pending_reg[dcsr_pkg::DSI_LSB +: 2];
            waitCode_reg <= pending_reg[dcsr_pkg::LAT_LSB +: 4];
        end
    end

    assign memBus.wrEn = latchTick & pendValid_reg;
    assign memBus.wrAddr = pending_reg[39:36];
    assign memBus.wrData = pending_reg[35:0];
    assign memBus.rdAddr = readAddr;
    assign readData = memBus.rdData;
    assign waitCode = waitCode_reg;

    dcsr_word_mem u_mem (
        .mclk(mclk),
        .arst_n(arst_n),
        .port(memBus)
    );

    // ****************************************
    // Downstream timing
    // ****************************************
    dcsr_pkg::dcsr_mode_t mode_reg;
    dcsr_pkg::dcsr_state_t st_reg;
    logic [2:0] phCnt_reg;
    logic [2:0] setupCyc;
    logic [2:0] highCyc;
    logic sckNext;
    logic datNext;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= dcsr_pkg::MODE0;
        end else begin
            mode_reg <= dcsr_pkg::mode_of(dsiField_reg);
        end
    end

    assign modeSel = mode_reg;
    assign setupCyc = (mode_reg == dcsr_pkg::MODE1)
        ? dcsr_pkg::M1_SETUP_CYC : dcsr_pkg::M2_SETUP_CYC;
    assign highCyc = (mode_reg == dcsr_pkg::MODE1)
        ? dcsr_pkg::M1_HIGH_CYC : dcsr_pkg::M2_HIGH_CYC;

    // Mode only changes at a latch, so never mid-pulse
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= dcsr_pkg::ST_IDLE;
            phCnt_reg <= '0;
        end else begin
            unique case (st_reg)
                dcsr_pkg::ST_IDLE: begin
                    if (sckRise && mode_reg != dcsr_pkg::MODE0) begin
                        st_reg <= dcsr_pkg::ST_SETUP;
                        phCnt_reg <= setupCyc;
                    end
                end
                dcsr_pkg::ST_SETUP: begin
                    if (phCnt_reg == 3'h1) begin
                        st_reg <= dcsr_pkg::ST_HIGH;
                        phCnt_reg <= highCyc;
                    end else begin
                        phCnt_reg <= phCnt_reg - 3'h1;
                    end
                end
                dcsr_pkg::ST_HIGH: begin
                    if (phCnt_reg == 3'h1) begin
                        st_reg <= dcsr_pkg::ST_IDLE;
                        phCnt_reg <= '0;
                    end else begin
                        phCnt_reg <= phCnt_reg - 3'h1;
                    end
                end
            endcase
        end
    end

    // In modes 1 and 2 data is loaded one cycle after the rise so bitSync has settled; mode 0 loads it at the fall
    always_comb begin
        sckNext = shiftClockOutPos;
        datNext = serialDataOutPos;
        if (mode_reg == dcsr_pkg::MODE0) begin
            sckNext = sckSync;
            if (sckFall) begin
                datNext = bitSync;
            end
        end else begin
            sckNext = (st_reg == dcsr_pkg::ST_SETUP && phCnt_reg == 3'h1)
                || (st_reg == dcsr_pkg::ST_HIGH && phCnt_reg != 3'h1);
            if (st_reg == dcsr_pkg::ST_SETUP && phCnt_reg == setupCyc) begin
                datNext = bitSync;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            shiftClockOutPos <= 1'b0;
            shiftClockOutNeg <= 1'b1;
            serialDataOutPos <= 1'b0;
            serialDataOutNeg <= 1'b1;
        end else begin
            shiftClockOutPos <= sckNext;
            shiftClockOutNeg <= ~sckNext;
            serialDataOutPos <= datNext;
            serialDataOutNeg <= ~datNext;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_m1_pulse;
        shiftClockOutPos [*2] ##1 !shiftClockOutPos;
    endsequence

    sequence s_m2_pulse;
        shiftClockOutPos ##1 !shiftClockOutPos;
    endsequence

    property p_mode_dec;
        @(posedge mclk) disable iff (!arst_n)
        (dsiField_reg[1] && $stable(dsiField_reg))
            |=> mode_reg == dcsr_pkg::MODE2;
    endproperty
    a_mode_dec: assert property (p_mode_dec) else $error("mode decode");

    property p_word_len;
        @(posedge shiftClockInPos) disable iff (!linkRst_n)
        (bitCnt_reg == dcsr_pkg::BIT_LAST) |=> bitCnt_reg == 6'h0;
    endproperty
    a_word_len: assert property (p_word_len) else $error("word length");

    property p_m0_clock;
        @(posedge mclk) disable iff (!arst_n)
        (mode_reg == dcsr_pkg::MODE0 && $stable(mode_reg) && sckFall)
            |=> !shiftClockOutPos;
    endproperty
    a_m0_clock: assert property (p_m0_clock) else $error("m0 clock");

    property p_m0_data;
        @(posedge mclk) disable iff (!arst_n)
        (mode_reg == dcsr_pkg::MODE0 && $stable(mode_reg)
            && $changed(serialDataOutPos)) |-> $past(sckFall);
    endproperty
    a_m0_data: assert property (p_m0_data) else $error("m0 data");

    property p_m1_width;
        @(posedge mclk) disable iff (!arst_n)
        (mode_reg == dcsr_pkg::MODE1 && $rose(shiftClockOutPos))
            |-> s_m1_pulse;
    endproperty
    a_m1_width: assert property (p_m1_width) else $error("m1 pulse");

    property p_m2_width;
        @(posedge mclk) disable iff (!arst_n)
        (mode_reg == dcsr_pkg::MODE2 && $rose(shiftClockOutPos))
            |-> s_m2_pulse;
    endproperty
    a_m2_width: assert property (p_m2_width) else $error("m2 pulse");

    property p_align;
        @(posedge mclk) disable iff (!arst_n)
        (mode_reg != dcsr_pkg::MODE0 && $rose(shiftClockOutPos))
            |-> $stable(serialDataOutPos);
    endproperty
    a_align: assert property (p_align) else $error("data edge");

    property p_restart;
        @(posedge mclk) disable iff (!arst_n)
        sckRise |=> armed_reg && idleCnt_reg == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("restart");

    property p_one_latch;
        @(posedge mclk) disable iff (!arst_n)
        latchPulse |-> !armed_reg ##1 !latchPulse;
    endproperty
    a_one_latch: assert property (p_one_latch) else $error("latch");

    property p_apply;
        @(posedge mclk) disable iff (!arst_n)
        (latchTick && pendValid_reg) |=> activeWord == $past(pending_reg);
    endproperty
    a_apply: assert property (p_apply) else $error("apply");

    property p_cfg;
        @(posedge mclk) disable iff (!arst_n)
        applyCfg |=> waitCode_reg == $past(pending_reg[dcsr_pkg::LAT_LSB +: 4]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("cfg word");

endmodule
`default_nettype wire

// file: inc/dcsr_pkg.sv
/*
  Constants for the daisy-chain serial repeater: word layout, field
  positions of the configuration word, reset values, output modes,
  sequencer states and latch wait timing.
  Assumes a 40 MHz system clock.
*/
package dcsr_pkg;

    // ****************************************
    // Word layout
    // ****************************************
    localparam int WORD_BITS = 40;
    localparam int ADDR_W = 4;
    localparam int PAY_W = 36;
    localparam logic [5:0] BIT_LAST = 6'h27;
    localparam logic [3:0] ADDR_CFG = 4'hc;
    localparam int DSI_LSB = 8;
    localparam int LAT_LSB = 10;
    localparam logic [1:0] DSI_RESET = 2'h0;
    localparam logic [3:0] LAT_RESET = 4'hf;

    // ****************************************
    // Modes and states
    // ****************************************
    typedef enum logic [1:0] {
        MODE0 = 2'h0,
        MODE1 = 2'h1,
        MODE2 = 2'h2
    } dcsr_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SETUP = 3'h2,
        ST_HIGH = 3'h4
    } dcsr_state_t;

    function automatic dcsr_mode_t mode_of(input logic [1:0] code);
        unique case (code)
            2'h0: return MODE0;
            2'h1: return MODE1;
            default: return MODE2;
        endcase
    endfunction

    // ****************************************
    // Timing
    // ****************************************
    localparam int MCLK_NS = 25;
    localparam int M1_SETUP_NS = 75;
    localparam int M1_HIGH_NS = 50;
    localparam int M2_SETUP_NS = 50;
    localparam int M2_HIGH_NS = 25;
    localparam int TMR_W = 20;

    // Least times round up, never below one cycle
    function automatic logic [2:0] cyc_ceil(input int ns);
        int c;
        c = (ns + MCLK_NS - 1) / MCLK_NS;
        return (c < 1) ? 3'h1 : 3'(c);
    endfunction

    localparam logic [2:0] M1_SETUP_CYC = cyc_ceil(M1_SETUP_NS);
    localparam logic [2:0] M1_HIGH_CYC = cyc_ceil(M1_HIGH_NS);
    localparam logic [2:0] M2_SETUP_CYC = cyc_ceil(M2_SETUP_NS);
    localparam logic [2:0] M2_HIGH_CYC = cyc_ceil(M2_HIGH_NS);

    typedef int unsigned dcsr_tab_t [16];
    localparam dcsr_tab_t LAT_WAIT_NS = '{
        400, 800, 1600, 3200, 6400, 12800, 25600, 51200,
        100000, 200000, 400000, 800000,
        1600000, 3300000, 6600000, 13100000
    };

    // Wait is a longest time: round down, at least one cycle
    function automatic dcsr_tab_t wait_cycles();
        dcsr_tab_t t;
        for (int i = 0; i < 16; i++) begin
            t[i] = LAT_WAIT_NS[i] / MCLK_NS;
            if (t[i] < 1) begin
                t[i] = 1;
            end
        end
        return t;
    endfunction

    localparam dcsr_tab_t LAT_WAIT_CYC = wait_cycles();

endpackage

// file: inc/dcsr_mem_if.sv
/*
  Bundle between the repeater core and its word store.
  Assumes the store samples everything on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface dcsr_mem_if;
    logic wrEn;
    logic [3:0] wrAddr;
    logic [35:0] wrData;
    logic [3:0] rdAddr;
    logic [35:0] rdData;
    modport ctrl (output wrEn, wrAddr, wrData, rdAddr, input rdData);
    modport mem (input wrEn, wrAddr, wrData, rdAddr, output rdData);
endinterface
`default_nettype wire

// file: verilog/dcsr_sync2.sv
/*
  Two flip-flop level synchroniser.
  Assumes the input changes slowly against the destination clock.
*/
`timescale 1ns/10ps
`default_nettype none
module dcsr_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// file: verilog/dcsr_word_mem.sv
/*
  Store of the sixteen active register payloads, registered read.
  Assumes one write per cycle from the repeater core.
*/
`timescale 1ns/10ps
`default_nettype none
module dcsr_word_mem (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Store port
    dcsr_mem_if.mem port
);
    logic [35:0] store_reg [16];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 16; i++) begin
                store_reg[i] <= '0;
            end
        end else if (port.wrEn) begin
            store_reg[port.wrAddr] <= port.wrData;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            port.rdData <= '0;
        end else begin
            port.rdData <= store_reg[port.rdAddr];
        end
    end
endmodule
`default_nettype wire

// file: verification/dcsr_host_model.sv
/*
  Upstream host model: shifts words MSB first on its own shift clock.
  Assumes the caller picks a bit rate legal for the repeater's mode.
*/
`timescale 1ns/10ps
`default_nettype none
module dcsr_host_model (
    // Link toward the repeater
    output logic shiftClockInPos,
    output logic serialDataInPos
);
    initial begin
        shiftClockInPos = 1'b0;
        serialDataInPos = 1'b0;
    end

    // ****************************************
    // Frame sender
    // ****************************************
    // Clock parks low between frames; caller keeps gaps below the wait
    task automatic send(input logic [39:0] w, input int n,
                        input realtime halfNs);
        #3.7;
        for (int i = 39; i > 39 - n; i--) begin
            serialDataInPos = w[i];
            #(halfNs);
            shiftClockInPos = 1'b1;
            #(halfNs);
            shiftClockInPos = 1'b0;
        end
        // Line left stale after a frame, so show the inverse
        serialDataInPos = ~serialDataInPos;
    endtask
endmodule
`default_nettype wire

// file: verification/daisy_chain_serial_repeater_bench.sv
/*
  Self-checking bench for the serial repeater: config words in every
  mode code, random words, latch timing, downstream repeat.
  Assumes the host model drives the upstream link.
*/
`timescale 1ns/10ps
`default_nettype none
module daisy_chain_serial_repeater_bench;
    // Short waits keep the run brief, still above in-frame gaps
    localparam dcsr_pkg::dcsr_tab_t WAITS = '{40, 48, 56, 64, 72, 80, 88,
        96, 104, 112, 120, 128, 136, 144, 152, 160};
    logic mclk;
    logic arst_n;
    wire logic sckIn;
    wire logic sdIn;
    logic sckOut;
    logic sckOutN;
    logic sdOut;
    logic sdOutN;
    logic latchPulse;
    logic [39:0] activeWord;
    logic [1:0] modeSel;
    logic [3:0] waitCode;
    logic [3:0] readAddr;
    logic [35:0] readData;
    int errTotal = 0;
    int testsRun = 0;
    int seed;
    int latchCnt = 0;
    int hiCnt = 0;
    logic prevClk = 1'b0;
    logic [1:0] curMode;
    logic [3:0] curWait;
    logic [39:0] expAct;
    logic [39:0] w;
    logic expQ[$];

    dcsr_host_model host (
        .shiftClockInPos(sckIn),
        .serialDataInPos(sdIn)
    );

    dcsr_repeater #(.LAT_WAIT_CYC(WAITS)) dut (
        .mclk(mclk),
        .arst_n(arst_n),
        .shiftClockInPos(sckIn),
        .serialDataInPos(sdIn),
        .shiftClockOutPos(sckOut),
        .shiftClockOutNeg(sckOutN),
        .serialDataOutPos(sdOut),
        .serialDataOutNeg(sdOutN),
        .latchPulse(latchPulse),
        .activeWord(activeWord),
        .modeSel(modeSel),
        .waitCode(waitCode),
        .readAddr(readAddr),
        .readData(readData)
    );

    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input string what, input logic [39:0] exp,
                       input logic [39:0] got);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [1:0] exp_mode(input logic [1:0] c);
        return (c == 2'h3) ? 2'h2 : c;
    endfunction

    function automatic logic [39:0] rnd_word();
        logic [39:0] r;
        r = {8'($random(seed)), 32'($random(seed))};
        if (r[39:36] == 4'hc) begin
            r[39:36] = 4'h0;
        end
        return r;
    endfunction

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Downstream monitor
    // ****************************************
    // Data is settled by the edge that drops the clock: earlier in modes 1 and 2, on that same edge in mode 0
    always @(negedge mclk) begin
        if (sckOut === 1'b1) begin
            hiCnt++;
        end
        if (prevClk === 1'b1 && sckOut === 1'b0) begin
            if (expQ.size() == 0) begin
                chk("extra bit", 40'h0, 40'h1);
            end else begin
                chk("data out", 40'(expQ.pop_front()), 40'(sdOut));
            end
            chk("data out neg", 40'(!sdOut), 40'(sdOutN));
            chk("clock out neg", 40'h1, 40'(sckOutN));
            if (curMode == 2'h1) begin
                chk("high mode1", 40'(dcsr_pkg::M1_HIGH_CYC), hiCnt);
            end else if (curMode == 2'h2) begin
                chk("high mode2", 40'(dcsr_pkg::M2_HIGH_CYC), hiCnt);
            end
            hiCnt = 0;
        end
        prevClk = sckOut;
        if (latchPulse === 1'b1) begin
            latchCnt++;
        end
    end

    // ****************************************
    // One frame, then latch and readback
    // ****************************************
    task automatic frame(input logic [39:0] fw, input int n, input bit pre);
        int cnt;
        int lc;
        logic [39:0] pw;
        realtime half;
        pw = rnd_word();
        lc = latchCnt;
        // Mode 1 pulse needs more than five system cycles per bit
        half = (curMode == 2'h1) ? 100.0 : 62.5;
        if (pre) begin
            for (int i = 39; i >= 0; i--) expQ.push_back(pw[i]);
        end
        for (int i = 39; i > 39 - n; i--) expQ.push_back(fw[i]);
        @(posedge mclk);
        #1;
        if (pre) begin
            host.send(pw, 40, half);
        end
        host.send(fw, n, half);
        cnt = 0;
        while (latchPulse !== 1'b1 && cnt < WAITS[curWait] + 20) begin
            @(posedge mclk);
            #1;
            cnt++;
        end
        testsRun++;
        if (cnt < WAITS[curWait] - 4 || cnt > WAITS[curWait] + 8) begin
            errTotal++;
            $display("BAD latch delay expected %0d seen %0d",
                     WAITS[curWait], cnt);
        end
        if (n == 40) begin
            expAct = fw;
        end else if (pre) begin
            expAct = pw;
        end
        @(posedge mclk);
        #1;
        chk("activeWord", expAct, activeWord);
        readAddr = expAct[39:36];
        repeat (2) @(posedge mclk);
        #1;
        chk("readData", 40'(expAct[35:0]), 40'(readData));
        repeat (WAITS[curWait] + 20) @(posedge mclk);
        #1;
        chk("latch count", 40'h1, 40'(latchCnt - lc));
        chk("bits left", 40'h0, 40'(expQ.size()));
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 35637;
        arst_n = 1'b0;
        readAddr = 4'h0;
        curMode = 2'h0;
        curWait = 4'hf;
        expAct = 40'h0;
        repeat (4) @(posedge mclk);
        #1;
        arst_n = 1'b1;
        chk("reset waitCode", 40'hf, 40'(waitCode));
        chk("reset modeSel", 40'h0, 40'(modeSel));
        chk("reset activeWord", 40'h0, activeWord);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            w = rnd_word();
            w[39:36] = 4'hc;
            w[9:8] = k[1:0];
            w[13:10] = 4'($random(seed));
            frame(w, 40, 1'b0);
            chk("modeSel", 40'(exp_mode(k[1:0])), 40'(modeSel));
            chk("waitCode", 40'(w[13:10]), 40'(waitCode));
            curMode = exp_mode(k[1:0]);
            curWait = w[13:10];
            frame(rnd_word(), 40, 1'b0);
            $display("test mode code %0d done", k);
        end
        frame(rnd_word(), 40, 1'b1);
        $display("test two words done");
        frame(rnd_word(), 20, 1'b0);
        $display("test partial word done");
        arst_n = 1'b0;
        curMode = 2'h0;
        curWait = 4'hf;
        repeat (2) @(posedge mclk);
        #1;
        chk("rereset waitCode", 40'hf, 40'(waitCode));
        chk("rereset modeSel", 40'h0, 40'(modeSel));
        arst_n = 1'b1;
        frame(rnd_word(), 40, 1'b0);
        $display("test second reset done");
        tally_and_finish();
    end

    // About 12 frames of well under 30000 ns each
    initial begin
        #1000000;
        errTotal++;
        $display("BAD watchdog expected end seen hang");
        tally_and_finish();
    end
endmodule
`default_nettype wire
